// ### csb_console.v
// console command interpreter: step, repeat, start, test, wait, boot
// Summary of operation
// - step count runs that many instructions
// - report halt code and pc each step
// - no count: one step, then space mode
// - each space runs one more instruction
// - carriage return leaves space mode to idle
// - host interrupts blocked during step command
// - repeat until ctrl-c, ctrl-p or break
// - repeat takes deposit, examine or initialize only
// - start: init, load pc, then continue
// - no address keeps current pc
// - at-sign uses last examined or deposited data
// - test: self-test then chosen diagnostic package
// - missing file: reload console program
// - file present: load and transfer control
// - codes 01 missing, 02 read error
// - wait blocks until power-up file done
// - one automatic cold and one warm attempt
// - power-up with switch on cold starts
// - momentary boot position cold starts
// - kernel halt with switch on cold starts
// - failed warm start with switch on
// - boot command cold starts os or supervisor
// - attempted flag set means boot failure
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "csb_defines.vh"
module csb_console (
    input wire clk_sys,
    input wire sys_rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire break_in,
    output wire cpu_step,
    input wire cpu_step_done,
    input wire [7:0] cpu_halt_code,
    input wire [31:0] cpu_pc,
    output wire prog_io_mode,
    output wire intr_block,
    output wire cpu_init,
    output wire pc_load,
    output reg [31:0] pc_load_data,
    output wire cpu_continue,
    output wire rep_exec,
    output reg [3:0] rep_op,
    input wire rep_done,
    output wire selftest_start,
    input wire selftest_done,
    output wire diag_load,
    output reg [1:0] diag_sel,
    input wire diag_found,
    input wire diag_missing,
    input wire diag_read_err,
    output wire diag_xfer,
    output wire console_reload,
    input wire pwrup_file_done,
    input wire powerup,
    input wire sw_on,
    input wire sw_boot,
    input wire halt_kernel,
    input wire warm_fail,
    input wire warm_req,
    output wire cold_start,
    output wire cold_sup,
    output wire warm_start
);
    // one-hot states
    localparam [12:0] S_IDLE = 13'h0001;
    localparam [12:0] S_SGO = 13'h0002;
    localparam [12:0] S_SWAIT = 13'h0004;
    localparam [12:0] S_SPACE = 13'h0008;
    localparam [12:0] S_REP = 13'h0010;
    localparam [12:0] S_INIT = 13'h0020;
    localparam [12:0] S_PCLD = 13'h0040;
    localparam [12:0] S_CONT = 13'h0080;
    localparam [12:0] S_SELF = 13'h0100;
    localparam [12:0] S_TLD = 13'h0200;
    localparam [12:0] S_TWAIT = 13'h0400;
    localparam [12:0] S_RELD = 13'h0800;
    localparam [12:0] S_WPU = 13'h1000;

    // register hit at a byte offset
    function hit;
        input [7:0] ofs;
        input [7:0] reg_ofs;
        begin
            hit = (ofs == reg_ofs);
        end
    endfunction

    // --------------------------------------------------------------
    // bus front end
    // --------------------------------------------------------------
    wire rd_stb, wr_stb;
    wire [7:0] rd_ofs, wr_ofs;

    csb_ahb_port u_port (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .rd_stb(rd_stb),
        .wr_stb(wr_stb),
        .rd_ofs(rd_ofs),
        .wr_ofs(wr_ofs)
    );

    // zero wait states, always okay; hsize is single word only
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    reg [12:0] st_r, st_nxt;
    reg [31:0] cmd_r, arg_r, last_r, pc_r;
    reg [7:0] halt_r, err_r;
    reg rpt_pend_r, err_pend_r, space_r, boot_fail_r;
    reg [15:0] cnt_r;
    wire boot_failed, cold_tried, warm_tried;

    wire cmd_wr = wr_stb & hit(wr_ofs, `CSB_OFS_CMD);
    wire key_wr = wr_stb & hit(wr_ofs, `CSB_OFS_KEY);
    wire [7:0] key = hwdata[7:0];
    wire rpt_rd = rd_stb & hit(rd_ofs, `CSB_OFS_RPT);

    // --------------------------------------------------------------
    // decode of an incoming command word
    // --------------------------------------------------------------
    wire [3:0] w_op = hwdata[`CSB_F_OP_LSB+3:`CSB_F_OP_LSB];
    wire w_arg = hwdata[`CSB_F_HASARG];
    wire w_at = hwdata[`CSB_F_AT];
    wire [1:0] w_q = hwdata[`CSB_F_QUAL_LSB+1:`CSB_F_QUAL_LSB];
    wire [3:0] w_sub = hwdata[`CSB_F_SUB_LSB+3:`CSB_F_SUB_LSB];
    wire [15:0] w_cnt = hwdata[`CSB_F_CNT_LSB+15:`CSB_F_CNT_LSB];
    wire sub_ok = (w_sub == `CSB_SUB_DEP) | (w_sub == `CSB_SUB_EXA)
        | (w_sub == `CSB_SUB_INIT);
    reg cmd_bad;

    always @* begin
        case (w_op)
            `CSB_OP_NEXT: cmd_bad = (w_q != `CSB_Q_NONE)
                | (w_arg & (w_cnt == `CSB_RST_CNT));
            `CSB_OP_REPEAT: cmd_bad = ~sub_ok;
            `CSB_OP_START: cmd_bad = (w_q != `CSB_Q_NONE);
            `CSB_OP_TEST: cmd_bad = (w_q == 2'h3);
            `CSB_OP_WAIT: cmd_bad = (w_q != `CSB_Q_NONE);
            `CSB_OP_BOOT: cmd_bad = w_q[1];
            default: cmd_bad = 1'b1;
        endcase
    end

    wire take = cmd_wr & st_r[0];
    wire bad_take = take & cmd_bad;
    wire boot_take = take & ~cmd_bad & (w_op == `CSB_OP_BOOT);
    wire stop_key = key_wr & ((key == `CSB_KEY_CTLC)
        | (key == `CSB_KEY_CTLP));
    wire last_step = (cnt_r == 16'h0001);

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always @* begin
        st_nxt = st_r;
        case (st_r)
            S_IDLE: begin
                if (take & ~cmd_bad) begin
                    case (w_op)
                        `CSB_OP_NEXT: st_nxt = S_SGO;
                        `CSB_OP_REPEAT: st_nxt = S_REP;
                        `CSB_OP_START: st_nxt = S_INIT;
                        `CSB_OP_TEST: st_nxt = S_SELF;
                        `CSB_OP_WAIT: st_nxt = pwrup_file_done ?
                            S_IDLE : S_WPU;
                        default: st_nxt = S_IDLE;
                    endcase
                end
            end
            // next step waits until the last report was read
            S_SGO: if (~rpt_pend_r) st_nxt = S_SWAIT;
            S_SWAIT: begin
                if (cpu_step_done) begin
                    if (~last_step) st_nxt = S_SGO;
                    else if (space_r) st_nxt = S_SPACE;
                    else st_nxt = S_IDLE;
                end
            end
            S_SPACE: begin
                if (key_wr & (key == `CSB_KEY_SPACE)) begin
                    st_nxt = S_SGO;
                end else if (key_wr & (key == `CSB_KEY_CR)) begin
                    st_nxt = S_IDLE;
                end
            end
            S_REP: if (stop_key | break_in) st_nxt = S_IDLE;
            S_INIT: st_nxt = S_PCLD;
            S_PCLD: st_nxt = S_CONT;
            S_CONT: st_nxt = S_IDLE;
            S_SELF: if (selftest_done) st_nxt = S_TLD;
            S_TLD: st_nxt = S_TWAIT;
            S_TWAIT: begin
                if (diag_missing) st_nxt = S_RELD;
                else if (diag_found) st_nxt = S_IDLE;
            end
            S_RELD: st_nxt = S_IDLE;
            S_WPU: if (pwrup_file_done) st_nxt = S_IDLE;
            default: st_nxt = S_IDLE;
        endcase
    end

    // --------------------------------------------------------------
    // state, command latch and step counter
    // --------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            st_r <= S_IDLE;
            cmd_r <= `CSB_RST_WORD;
            cnt_r <= `CSB_RST_CNT;
            space_r <= 1'b0;
            rep_op <= 4'h0;
            diag_sel <= `CSB_Q_NONE;
        end else begin
            st_r <= st_nxt;
            if (take & ~cmd_bad) begin
                cmd_r <= hwdata;
                rep_op <= w_sub;
                diag_sel <= w_q;
                cnt_r <= w_arg ? w_cnt : 16'h0001;
                space_r <= ~w_arg;
            end else if (st_r[2] & cpu_step_done & ~last_step) begin
                cnt_r <= cnt_r - 16'h0001;
            end
        end
    end

    // --------------------------------------------------------------
    // step report: halt code and pc of every step
    // --------------------------------------------------------------
    // a new report beats a read clearing the old one
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            halt_r <= 8'h00;
            pc_r <= `CSB_RST_WORD;
            rpt_pend_r <= 1'b0;
        end else if (st_r[2] & cpu_step_done) begin
            halt_r <= cpu_halt_code;
            pc_r <= cpu_pc;
            rpt_pend_r <= 1'b1;
        end else if (rpt_rd) begin
            rpt_pend_r <= 1'b0;
        end
    end

    // error code; read errors repeat while loading, latest is kept
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            err_r <= `CSB_ERR_NONE;
            err_pend_r <= 1'b0;
        end else if (bad_take) begin
            err_r <= `CSB_ERR_BADCMD;
            err_pend_r <= 1'b1;
        end else if (st_r[10] & diag_missing) begin
            err_r <= `CSB_ERR_NOFILE;
            err_pend_r <= 1'b1;
        end else if (st_r[10] & diag_read_err) begin
            err_r <= `CSB_ERR_READ;
            err_pend_r <= 1'b1;
        end else if (rpt_rd) begin
            err_pend_r <= 1'b0;
        end
    end

    // argument and last examined or deposited data
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            arg_r <= `CSB_RST_WORD;
            last_r <= `CSB_RST_WORD;
            pc_load_data <= `CSB_RST_WORD;
        end else begin
            if (wr_stb & hit(wr_ofs, `CSB_OFS_ARG)) arg_r <= hwdata;
            if (wr_stb & hit(wr_ofs, `CSB_OFS_LAST)) last_r <= hwdata;
            if (st_r[5]) begin
                pc_load_data <= cmd_r[`CSB_F_AT] ? last_r : arg_r;
            end
        end
    end

    // --------------------------------------------------------------
    // host control strobes
    // --------------------------------------------------------------
    assign cpu_step = st_r[1] & ~rpt_pend_r;
    assign prog_io_mode = st_r[1] | st_r[2];
    assign intr_block = st_r[1] | st_r[2] | st_r[3];
    assign cpu_init = st_r[5];
    // without an address the pc is left alone
    assign pc_load = st_r[6] & (cmd_r[`CSB_F_HASARG]
        | cmd_r[`CSB_F_AT]);
    assign cpu_continue = st_r[7];
    assign rep_exec = st_r[4] & ~stop_key & ~break_in;
    assign selftest_start = st_r[8] & ~selftest_done;
    assign diag_load = st_r[9];
    assign diag_xfer = st_r[10] & diag_found & ~diag_missing;
    assign console_reload = st_r[11];

    // cold and warm start control
    csb_boot_ctl u_boot (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .powerup(powerup),
        .sw_on(sw_on),
        .sw_boot(sw_boot),
        .halt_kernel(halt_kernel),
        .warm_fail(warm_fail),
        .warm_req(warm_req),
        .boot_cmd(boot_take),
        .boot_sup(w_q[0]),
        .in_wait_loop(st_r[0]),
        .cold_start(cold_start),
        .cold_sup(cold_sup),
        .boot_failed(boot_failed),
        .warm_start(warm_start),
        .cold_tried(cold_tried),
        .warm_tried(warm_tried)
    );

    // boot failure sticks until the report register is read
    always @(posedge clk_sys) begin
        if (sys_rst) boot_fail_r <= 1'b0;
        else if (boot_failed) boot_fail_r <= 1'b1;
        else if (rpt_rd) boot_fail_r <= 1'b0;
    end

    // --------------------------------------------------------------
    // read data, registered in the address phase
    // --------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            hrdata <= `CSB_RST_WORD;
        end else if (rd_stb) begin
            case (rd_ofs)
                `CSB_OFS_CMD: hrdata <= cmd_r;
                `CSB_OFS_ARG: hrdata <= arg_r;
                `CSB_OFS_STAT: hrdata <= {11'h000, cold_tried,
                    warm_tried, boot_fail_r, err_pend_r,
                    rpt_pend_r, 3'h0, st_r};
                `CSB_OFS_RPT: hrdata <= {16'h0000, err_r, halt_r};
                `CSB_OFS_PC: hrdata <= pc_r;
                `CSB_OFS_LAST: hrdata <= last_r;
                `CSB_OFS_CNT: hrdata <= {16'h0000, cnt_r};
                default: hrdata <= `CSB_RST_WORD;
            endcase
        end
    end
endmodule // csb_console

// ### csb_defines.vh
// constants shared by the console step, start and boot control block
`ifndef CSB_DEFINES_VH
`define CSB_DEFINES_VH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define CSB_OFS_CMD 8'h00
`define CSB_OFS_ARG 8'h04
`define CSB_OFS_KEY 8'h08
`define CSB_OFS_STAT 8'h0C
`define CSB_OFS_RPT 8'h10
`define CSB_OFS_PC 8'h14
`define CSB_OFS_LAST 8'h18
`define CSB_OFS_CNT 8'h1C
// ----------------------------------------------------------------------
// command register fields
// ----------------------------------------------------------------------
`define CSB_F_OP_LSB 0
`define CSB_F_HASARG 4
`define CSB_F_AT 5
`define CSB_F_QUAL_LSB 6
`define CSB_F_SUB_LSB 8
`define CSB_F_CNT_LSB 16
// ----------------------------------------------------------------------
// opcodes, qualifiers, repeat commands, keys and error codes
// ----------------------------------------------------------------------
`define CSB_OP_NEXT 4'h1
`define CSB_OP_REPEAT 4'h2
`define CSB_OP_START 4'h3
`define CSB_OP_TEST 4'h4
`define CSB_OP_WAIT 4'h5
`define CSB_OP_BOOT 4'h6
`define CSB_Q_NONE 2'h0
`define CSB_Q_MENU 2'h1
`define CSB_Q_MICRO 2'h2
`define CSB_SUB_DEP 4'h1
`define CSB_SUB_EXA 4'h2
`define CSB_SUB_INIT 4'h3
`define CSB_KEY_SPACE 8'h20
`define CSB_KEY_CR 8'h0D
`define CSB_KEY_CTLC 8'h03
`define CSB_KEY_CTLP 8'h10
`define CSB_ERR_NONE 8'h00
`define CSB_ERR_NOFILE 8'h01
`define CSB_ERR_READ 8'h02
`define CSB_ERR_BADCMD 8'h03
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CSB_RST_WORD 32'h0000_0000
`define CSB_RST_CNT 16'h0000
`endif

// ### csb_ahb_port.v
// ahb-lite slave front end: address phase capture and strobes
`timescale 1ns/1ns
module csb_ahb_port (
    input wire clk_sys,
    input wire sys_rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    output wire rd_stb,
    output reg wr_stb,
    output wire [7:0] rd_ofs,
    output reg [7:0] wr_ofs
);
    // --------------------------------------------------------------
    // address phase decode
    // --------------------------------------------------------------
    // nonseq and seq both count; idle and busy are ignored
    wire xfer = hsel & hready & htrans[1];

    assign rd_stb = xfer & ~hwrite;
    assign rd_ofs = haddr[7:0];

    // write held over into the data phase, where hwdata stands
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            wr_stb <= 1'b0;
            wr_ofs <= 8'h00;
        end else begin
            wr_stb <= xfer & hwrite;
            wr_ofs <= haddr[7:0];
        end
    end
endmodule // csb_ahb_port

// ### csb_boot_ctl.v
// cold and warm start arbitration with one-attempt flags
`timescale 1ns/1ns
module csb_boot_ctl (
    input wire clk_sys,
    input wire sys_rst,
    input wire powerup,
    input wire sw_on,
    input wire sw_boot,
    input wire halt_kernel,
    input wire warm_fail,
    input wire warm_req,
    input wire boot_cmd,
    input wire boot_sup,
    input wire in_wait_loop,
    output reg cold_start,
    output reg cold_sup,
    output reg boot_failed,
    output reg warm_start,
    output reg cold_tried,
    output reg warm_tried
);
    // --------------------------------------------------------------
    // boot position edge: armed only once the switch is released
    // --------------------------------------------------------------
    reg boot_armed_r;
    wire boot_press = sw_boot & boot_armed_r & in_wait_loop;
    // refused warm start counts as a failed one
    wire warm_lost = warm_req & warm_tried;
    wire auto_req = (powerup & sw_on)
        | boot_press
        | (halt_kernel & sw_on)
        | ((warm_fail | warm_lost) & sw_on);

    // attempt flags and start pulses
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            boot_armed_r <= 1'b0;
            cold_start <= 1'b0;
            cold_sup <= 1'b0;
            boot_failed <= 1'b0;
            warm_start <= 1'b0;
            cold_tried <= 1'b0;
            warm_tried <= 1'b0;
        end else begin
            boot_armed_r <= ~sw_boot;
            cold_start <= 1'b0;
            boot_failed <= 1'b0;
            warm_start <= 1'b0;
            if (boot_cmd) begin
                // operator boot always goes ahead, flag is only set
                cold_tried <= 1'b1;
                cold_start <= 1'b1;
                cold_sup <= boot_sup;
            end else if (auto_req) begin
                if (cold_tried) begin
                    boot_failed <= 1'b1;
                end else begin
                    cold_tried <= 1'b1;
                    cold_start <= 1'b1;
                    cold_sup <= 1'b0;
                end
            end
            if (warm_req & ~warm_tried) begin
                warm_tried <= 1'b1;
                warm_start <= 1'b1;
            end
        end
    end
endmodule // csb_boot_ctl

// ### csb_host_model.sv
// host cpu and diagnostic drive stand-in for the console bench
`timescale 1ns/1ns
module csb_host_model (
    input wire clk_sys,
    input wire cpu_step,
    input wire selftest_start,
    input wire diag_load,
    input wire [1:0] diag_mode,
    output reg cpu_step_done,
    output wire [7:0] cpu_halt_code,
    output reg [31:0] cpu_pc,
    output reg selftest_done,
    output reg diag_found,
    output reg diag_missing,
    output reg diag_read_err,
    output integer steps
);
// host responses
reg step_q;
reg [2:0] dly;
reg [2:0] dg;
reg [7:0] hc_r;
// code is only held with done, scrambled otherwise
assign cpu_halt_code = cpu_step_done ? hc_r : ~hc_r;
initial begin
    {cpu_step_done, selftest_done, step_q} = 3'h0;
    {diag_found, diag_missing, diag_read_err} = 3'h0;
    {dly, dg} = 6'h00;
    hc_r = 8'h10;
    cpu_pc = 32'h0000_0200;
    steps = 0;
end
// an instruction ends four cycles after the request rises
always @(posedge clk_sys) begin
    step_q <= cpu_step;
    cpu_step_done <= (dly == 3'h1);
    if (cpu_step && !step_q)
        dly <= 3'h3;
    else if (dly != 3'h0)
        dly <= dly - 3'h1;
    if (dly == 3'h1) begin
        steps <= steps + 1;
        hc_r <= hc_r + 8'h01;
        cpu_pc <= cpu_pc + 32'h4;
    end
end
// self-test answers at once; the drive answers as diag_mode says
always @(posedge clk_sys) begin
    selftest_done <= selftest_start && !selftest_done;
    dg <= diag_load ? 3'h4 : dg - {2'h0, dg != 3'h0};
    diag_read_err <= dg == 3'h3 && diag_mode == 2'h2;
    diag_found <= dg == 3'h1 && diag_mode != 2'h1;
    diag_missing <= dg == 3'h1 && diag_mode == 2'h1;
end
endmodule // csb_host_model

// ### csb_console_sva.sv
// assertions on the console interpreter ports
`timescale 1ns/1ns
module csb_console_sva (
    input wire clk_sys,
    input wire sys_rst,
    input wire cpu_step,
    input wire intr_block,
    input wire prog_io_mode,
    input wire cpu_init,
    input wire pc_load,
    input wire cpu_continue,
    input wire rep_exec,
    input wire [3:0] rep_op,
    input wire break_in,
    input wire diag_xfer,
    input wire diag_found,
    input wire console_reload,
    input wire diag_missing,
    input wire diag_load,
    input wire selftest_done
);
// host control sequencing
default clocking cb @(posedge clk_sys); endclocking
default disable iff (sys_rst);
a_step_blocked: assert property (cpu_step |-> intr_block && prog_io_mode)
    else $error("step with interrupts open");
a_init_cont: assert property (cpu_init |-> ##[1:2] cpu_continue)
    else $error("no continue after init");
a_load_order: assert property (pc_load |-> $past(cpu_init) ##1 cpu_continue)
    else $error("pc load out of order");
a_rep_legal: assert property (rep_exec |-> rep_op inside {4'h1, 4'h2, 4'h3})
    else $error("illegal embedded command");
a_rep_break: assert property (rep_exec ##1 break_in |=> !rep_exec [*6])
    else $error("repeat ignores break");
a_xfer_found: assert property (diag_xfer |-> diag_found && !console_reload)
    else $error("transfer without file");
a_reload_miss: assert property (console_reload |-> $past(diag_missing))
    else $error("reload without missing file");
a_diag_order: assert property (diag_load |-> $past(selftest_done))
    else $error("load before self-test end");
endmodule // csb_console_sva
bind csb_console csb_console_sva csb_console_sva_inst (.*);

// ### testbench.sv
// self-checking bench for the console step, start and boot control
`timescale 1ns/1ns
`include "csb_defines.vh"
module testbench;
reg clk_sys, sys_rst, hsel, hwrite, break_in, pwrup_file_done, powerup;
reg sw_on, sw_boot, halt_kernel, warm_fail, warm_req, rep_done;
reg [31:0] haddr, hwdata, rd, last_pc, exp_pc;
reg [1:0] htrans, diag_mode, last_sel;
reg [2:0] hsize;
reg [7:0] exp_hc;
wire [31:0] hrdata, cpu_pc, pc_load_data;
wire [7:0] cpu_halt_code;
wire [3:0] rep_op;
wire [1:0] diag_sel;
wire hreadyout, hresp, cpu_step, cpu_step_done, prog_io_mode, intr_block;
wire cpu_init, pc_load, cpu_continue, rep_exec, selftest_start;
wire selftest_done, diag_load, diag_found, diag_missing, diag_read_err;
wire diag_xfer, console_reload, cold_start, cold_sup, warm_start;
integer steps, mismatches, comparisons, n_load, n_cont, n_xfer, n_rel, n_cold;
csb_console csb_console_inst (.hready(hreadyout), .*);
csb_host_model csb_host_model_inst (.*);
// free-running 10 ns clock
initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
end
// count host pulses; the scenarios compare the deltas
always @(posedge clk_sys) begin
    if (pc_load === 1'b1) last_pc <= pc_load_data;
    if (diag_load === 1'b1) last_sel <= diag_sel;
    n_load <= n_load + (pc_load === 1'b1);
    n_cont <= n_cont + (cpu_continue === 1'b1);
    n_xfer <= n_xfer + (diag_xfer === 1'b1);
    n_rel <= n_rel + (console_reload === 1'b1);
    n_cold <= n_cold + (cold_start === 1'b1);
end
task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
task chk(input [8*8:1] nm, input [31:0] got, input [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("FAIL %0s expected %h seen %h", nm, exp, got);
    end
endtask
// one edge, then wait for hready under a bound
task edge_rdy;
    integer k;
    @(posedge clk_sys);
    for (k = 0; hreadyout !== 1'b1; k = k + 1) begin
        if (k > 20) begin
            mismatches = mismatches + 1;
            final_report;
        end
        @(posedge clk_sys);
    end
endtask
// single word transfer; read data lands in rd
task bus(input w, input [7:0] a, input [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    edge_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy;
    rd = hrdata;
endtask
// poll a status bit; a bit that never sets ends the run
task poll(input integer b);
    integer k;
    for (k = 0; k < 60; k = k + 1) begin
        bus(1'b0, `CSB_OFS_STAT, 32'h0);
        if (rd[b] === 1'b1) begin
            comparisons = comparisons + 1;
            return;
        end
    end
    mismatches = mismatches + 1;
    final_report;
endtask
// pc first: reading the report lets the next step go
task chk_step;
    exp_hc = exp_hc + 8'h01;
    exp_pc = exp_pc + 32'h4;
    poll(16);
    bus(1'b0, `CSB_OFS_PC, 32'h0);
    chk("pc", rd, exp_pc);
    bus(1'b0, `CSB_OFS_RPT, 32'h0);
    chk("halt", rd[7:0], exp_hc);
endtask
// ----------------------------------------------------------------------
// scenarios
// ----------------------------------------------------------------------
task t_next;
    integer s0;
    s0 = steps;
    bus(1'b1, `CSB_OFS_CMD, 32'h0002_0011);
    chk_step;
    chk_step;
    poll(0);
    chk("steps", steps - s0, 2);
    bus(1'b1, `CSB_OFS_CMD, 32'h0000_0001);
    chk_step;
    poll(3);
    chk("blk", {intr_block, prog_io_mode}, 2'h2);
    bus(1'b1, `CSB_OFS_KEY, {24'h0, `CSB_KEY_SPACE});
    chk_step;
    bus(1'b1, `CSB_OFS_KEY, {24'h0, `CSB_KEY_CR});
    poll(0);
    chk("steps", steps - s0, 4);
endtask
// start with address, with at-sign, and with neither
task t_start;
    integer i, l0, c0;
    chk("resp", {hresp, hreadyout}, 2'h1);
    bus(1'b1, `CSB_OFS_ARG, 32'h0000_1000);
    bus(1'b1, `CSB_OFS_LAST, 32'h0000_2468);
    for (i = 0; i < 3; i = i + 1) begin
        l0 = n_load;
        c0 = n_cont;
        bus(1'b1, `CSB_OFS_CMD, i == 0 ? 32'h13 : i == 1 ? 32'h23 : 32'h03);
        poll(0);
        chk("cont", n_cont - c0, 1);
        chk("loads", n_load - l0, i < 2);
        if (i < 2) chk("pc_data", last_pc, i ? 32'h2468 : 32'h1000);
    end
endtask
// missing file, read error then found, found at once
task t_test;
    integer q, x0, r0;
    for (q = 0; q < 3; q = q + 1) begin
        diag_mode <= q == 0 ? 2'h1 : q == 1 ? 2'h2 : 2'h0;
        x0 = n_xfer;
        r0 = n_rel;
        bus(1'b1, `CSB_OFS_CMD, 32'h04 | (q << 6));
        poll(0);
        chk("sel", last_sel, q);
        chk("xfer", n_xfer - x0, q != 0);
        chk("reload", n_rel - r0, q == 0);
        bus(1'b0, `CSB_OFS_RPT, 32'h0);
        if (q < 2) chk("err", rd[15:8], q + 1);
    end
endtask
// each embedded command with its own way out, then bad lines
task t_repeat;
    integer i;
    for (i = 1; i < 4; i = i + 1) begin
        bus(1'b1, `CSB_OFS_CMD, 32'h02 | (i << 8));
        @(negedge clk_sys);
        chk("rep", {rep_exec, rep_op}, {1'b1, i[3:0]});
        @(posedge clk_sys);
        if (i == 3) break_in <= 1'b1;
        else bus(1'b1, `CSB_OFS_KEY, i == 1 ? 32'h03 : 32'h10);
        poll(0);
        break_in <= 1'b0;
    end
    for (i = 0; i < 2; i = i + 1) begin
        bus(1'b1, `CSB_OFS_CMD, i ? 32'h0402 : 32'h0);
        poll(0);
        bus(1'b0, `CSB_OFS_RPT, 32'h0);
        chk("bad", rd[15:8], `CSB_ERR_BADCMD);
    end
endtask
// wait for the power-up file, then two power-ups with switch on
task t_boot;
    integer c0, i;
    bus(1'b1, `CSB_OFS_CMD, 32'h05);
    poll(12);
    pwrup_file_done <= 1'b1;
    poll(0);
    c0 = n_cold;
    sw_on <= 1'b1;
    repeat (2) begin
        powerup <= 1'b1;
        @(posedge clk_sys);
        powerup <= 1'b0;
        repeat (3) @(posedge clk_sys);
    end
    chk("cold", n_cold - c0, 1);
    bus(1'b0, `CSB_OFS_STAT, 32'h0);
    chk("fail", rd[20:18], 3'h5);
    // each later trigger meets the set flag and reports failure
    for (i = 0; i < 3; i = i + 1) begin
        bus(1'b0, `CSB_OFS_RPT, 32'h0);
        {halt_kernel, warm_fail, sw_boot} <= 3'h4 >> i;
        @(posedge clk_sys);
        {halt_kernel, warm_fail, sw_boot} <= 3'h0;
        repeat (2) @(posedge clk_sys);
        bus(1'b0, `CSB_OFS_STAT, 32'h0);
        chk("fail", rd[18], 1'b1);
    end
    bus(1'b1, `CSB_OFS_CMD, 32'h46);
    repeat (2) @(posedge clk_sys);
    chk("boot", n_cold - c0, 2);
    chk("sup", cold_sup, 1'b1);
endtask
initial begin
    {hsel, hwrite, break_in, pwrup_file_done, powerup, sw_on} = 6'h00;
    {sw_boot, halt_kernel, warm_fail, warm_req, rep_done} = 5'h00;
    {haddr, hwdata, htrans, diag_mode} = 68'h0;
    hsize = 3'h2;
    {mismatches, comparisons, n_load, n_cont, n_xfer, n_rel, n_cold} = 0;
    exp_hc = 8'h10;
    exp_pc = 32'h0000_0200;
    sys_rst = 1'b1;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_next;
    t_start;
    t_test;
    t_repeat;
    t_boot;
    final_report;
end
endmodule // testbench
